// ===== rtl/uosp_otg_ctrl.sv
// OTG status, line control and power control registers behind APB.
// Assumes transceiver and comparator inputs synchronous to the
// partner side only; they are synchronised here to pclk.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "uosp_consts.svh"

// Function
// - identity bit reads 1 unless A cable
// - line stable flag after 1 ms unchanged
// - session valid flag follows comparator
// - B session end flag below threshold
// - A vbus valid flag above threshold
// - upper and unassigned bits read zero
// - bits 7..4 drive four line resistors
// - sw_line_control_en selects software resistor control
// - vbus_power_on powers VBUS
// - vbus_charge_en connects charge resistor
// - vbus_discharge_en connects discharge resistor
// - activity_pending while wake interrupt not generated
// - sleep_guard blocks sleep on activity or pending
// - module_busy while active or settling
// - suspend gates 48 MHz clock, transceiver low
// - power enable off holds line, VBUS, clock and analog outputs inactive
module uosp_otg_ctrl
  import uosp_pkg::*;
#(
  parameter int unsigned STABLE_CYC = `UOSP_STABLE_CYC
) (
  // System
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire uosp_pkg::uosp_addr_t paddr,
  input wire uosp_pkg::uosp_word_t pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output uosp_pkg::uosp_word_t prdata,
  output logic pslverr,
  // Transceiver and VBUS status
  input wire logic cable_identity,
  input wire logic single_ended_zero,
  input wire logic j_line_state,
  input wire logic sess_valid_cmp,
  input wire logic sess_end_cmp,
  input wire logic vbus_valid_cmp,
  input wire logic bus_activity,
  // Hardware resistor requests from the USB engine
  input wire logic [3:0] hw_line_res,
  // Line and VBUS drive
  output logic dplus_pullup_en,
  output logic dminus_pullup_en,
  output logic dplus_pulldown_en,
  output logic dminus_pulldown_en,
  output logic vbus_power_on,
  output logic vbus_charge_en,
  output logic vbus_discharge_en,
  // Power and clocking
  output logic usb_clk_gate_en,
  output logic xcvr_low_power,
  output logic usb_pins_owned,
  output logic analog_en,
  output logic sleep_block,
  // Interrupt
  output logic irq
);
  import uosp_pkg::*;

  localparam int N_SYNC = 7;
  localparam logic [15:0] STABLE_LAST = 16'(STABLE_CYC - 1);
  // Idle levels: no cable, SE0 on an empty bus, no VBUS
  localparam logic [N_SYNC-1:0] SYNC_IDLE = 7'h13;

  logic [N_SYNC-1:0] sync_in;
  logic [N_SYNC-1:0] sync1_reg;
  logic [N_SYNC-1:0] sync2_reg;
  logic [N_SYNC-1:0] prev_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] pwr_reg;
  logic [`UOSP_EV_WIDTH-1:0] evt_flag_reg;
  logic [`UOSP_EV_WIDTH-1:0] evt_mask_reg;
  logic [`UOSP_EV_WIDTH-1:0] evt_set;
  logic [15:0] stable_cnt_reg;
  logic line_stable_reg;
  logic line_change;
  logic [4:0] settle_cnt_reg;
  uosp_pstate_t pstate_reg;
  uosp_word_t rd_word;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic powered;
  logic busy;

  assign sync_in = {bus_activity, vbus_valid_cmp, sess_end_cmp,
                    sess_valid_cmp, j_line_state, single_ended_zero,
                    cable_identity};

  // Two-flop synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= SYNC_IDLE[gi];
          sync2_reg[gi] <= SYNC_IDLE[gi];
          prev_reg[gi] <= SYNC_IDLE[gi];
        end else if (clk_en) begin
          sync1_reg[gi] <= sync_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // SE0 or J changed after synchronisation
  assign line_change = (sync2_reg[2:1] != prev_reg[2:1]);

  // Line state stability timer
  // Counter saturates; flag holds until the next change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_cnt_reg <= 16'h0000;
      line_stable_reg <= 1'b0;
    end else if (clk_en) begin
      if (line_change) begin
        stable_cnt_reg <= 16'h0000;
        line_stable_reg <= 1'b0;
      end else if (stable_cnt_reg == STABLE_LAST) begin
        line_stable_reg <= 1'b1;
      end else begin
        stable_cnt_reg <= stable_cnt_reg + 16'h0001;
      end
    end
  end

  assign powered = pwr_reg[`UOSP_PW_ENABLE];

  // Module power sequencing
  // Disable waits out a settle period before re-enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_reg <= UOSP_OFF;
      settle_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      unique case (pstate_reg)
        UOSP_OFF: begin
          if (powered) begin
            pstate_reg <= UOSP_ON;
          end
        end
        UOSP_ON: begin
          if (!powered) begin
            pstate_reg <= UOSP_SETTLE;
            settle_cnt_reg <= 5'h00;
          end
        end
        UOSP_SETTLE: begin
          if (settle_cnt_reg == 5'(`UOSP_SETTLE_CYC - 1)) begin
            pstate_reg <= UOSP_OFF;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 5'h01;
          end
        end
        default: begin
          pstate_reg <= UOSP_OFF;
        end
      endcase
    end
  end

  // Busy also covers the settle period after disable
  assign busy = (pstate_reg != UOSP_OFF);

  // APB decode; one wait-free access phase
  assign addr_ok = (paddr == `UOSP_OFF_STATUS) ||
                   (paddr == `UOSP_OFF_CONTROL) ||
                   (paddr == `UOSP_OFF_POWER) ||
                   (paddr == `UOSP_OFF_EVT_FLAG) ||
                   (paddr == `UOSP_OFF_EVT_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  // Writes need pstrb[0]; unmapped offsets are dropped
  assign wr_en = psel && penable && pwrite && pstrb[0] && clk_en;
  // Read data is captured in the setup cycle
  assign rd_en = psel && !penable && !pwrite && clk_en;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `UOSP_CTRL_RESET;
    end else if (wr_en && paddr == `UOSP_OFF_CONTROL) begin
      ctrl_reg <= pwdata[7:0] & `UOSP_CT_MASK;
    end
  end

  // Power control register; busy and pending bits are live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= `UOSP_PWR_RESET;
    end else if (wr_en && paddr == `UOSP_OFF_POWER) begin
      pwr_reg <= pwdata[7:0] & `UOSP_PW_WMASK;
    end
  end

  // Event detection: changes on status lines and bus activity
  always_comb begin
    evt_set = '0;
    evt_set[`UOSP_EV_ID] = sync2_reg[0] ^ prev_reg[0];
    evt_set[`UOSP_EV_LSTABLE] = (stable_cnt_reg == STABLE_LAST)
                                && !line_stable_reg
                                && !line_change;
    evt_set[`UOSP_EV_SESSVALID] = sync2_reg[3] ^ prev_reg[3];
    evt_set[`UOSP_EV_SESSEND] = sync2_reg[4] ^ prev_reg[4];
    evt_set[`UOSP_EV_VBUSVALID] = sync2_reg[5] ^ prev_reg[5];
    evt_set[`UOSP_EV_ACTIVITY] = sync2_reg[6] && !prev_reg[6];
  end

  // Sticky flags, write one to clear; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_flag_reg <= '0;
    end else if (clk_en) begin
      if (wr_en && paddr == `UOSP_OFF_EVT_FLAG) begin
        evt_flag_reg <= (evt_flag_reg & ~pwdata[`UOSP_EV_WIDTH-1:0])
                        | evt_set;
      end else begin
        evt_flag_reg <= evt_flag_reg | evt_set;
      end
    end
  end

  // Event mask, same layout as the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_reg <= '0;
    end else if (wr_en && paddr == `UOSP_OFF_EVT_MASK) begin
      evt_mask_reg <= pwdata[`UOSP_EV_WIDTH-1:0];
    end
  end

  // Level interrupt from unmasked sticky flags
  assign irq = |(evt_flag_reg & evt_mask_reg);

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == `UOSP_OFF_STATUS) begin
      rd_word[`UOSP_ST_ID] = sync2_reg[0];
      rd_word[`UOSP_ST_LSTABLE] = line_stable_reg;
      rd_word[`UOSP_ST_SESSVALID] = sync2_reg[3];
      rd_word[`UOSP_ST_SESSEND] = sync2_reg[4];
      rd_word[`UOSP_ST_VBUSVALID] = sync2_reg[5];
    end else if (paddr == `UOSP_OFF_CONTROL) begin
      rd_word[7:0] = ctrl_reg;
    end else if (paddr == `UOSP_OFF_POWER) begin
      rd_word[7:0] = pwr_reg;
      rd_word[`UOSP_PW_BUSY] = busy;
      // Pending: flagged but not yet enabled to interrupt
      rd_word[`UOSP_PW_ACTPND] =
        evt_flag_reg[`UOSP_EV_ACTIVITY] &&
        !evt_mask_reg[`UOSP_EV_ACTIVITY];
    end else if (paddr == `UOSP_OFF_EVT_FLAG) begin
      rd_word[`UOSP_EV_WIDTH-1:0] = evt_flag_reg;
    end else if (paddr == `UOSP_OFF_EVT_MASK) begin
      rd_word[`UOSP_EV_WIDTH-1:0] = evt_mask_reg;
    end
  end

  // Holds until the next read setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_word;
    end
  end

  // Line and VBUS outputs, held inactive while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dplus_pullup_en <= 1'b0;
      dminus_pullup_en <= 1'b0;
      dplus_pulldown_en <= 1'b0;
      dminus_pulldown_en <= 1'b0;
      vbus_power_on <= 1'b0;
      vbus_charge_en <= 1'b0;
      vbus_discharge_en <= 1'b0;
    end else if (clk_en) begin
      if (!powered) begin
        dplus_pullup_en <= 1'b0;
        dminus_pullup_en <= 1'b0;
        dplus_pulldown_en <= 1'b0;
        dminus_pulldown_en <= 1'b0;
        vbus_power_on <= 1'b0;
        vbus_charge_en <= 1'b0;
        vbus_discharge_en <= 1'b0;
      end else begin
        if (ctrl_reg[`UOSP_CT_SW_LINE]) begin
          dplus_pullup_en <= ctrl_reg[`UOSP_CT_DP_PU];
          dminus_pullup_en <= ctrl_reg[`UOSP_CT_DM_PU];
          dplus_pulldown_en <= ctrl_reg[`UOSP_CT_DP_PD];
          dminus_pulldown_en <= ctrl_reg[`UOSP_CT_DM_PD];
        end else begin
          // Hardware mode follows the USB engine's requests
          dplus_pullup_en <= hw_line_res[3];
          dminus_pullup_en <= hw_line_res[2];
          dplus_pulldown_en <= hw_line_res[1];
          dminus_pulldown_en <= hw_line_res[0];
        end
        vbus_power_on <= ctrl_reg[`UOSP_CT_VBUS_ON];
        vbus_charge_en <= ctrl_reg[`UOSP_CT_VBUS_CHG];
        vbus_discharge_en <= ctrl_reg[`UOSP_CT_VBUS_DIS];
      end
    end
  end

  // Clock gating, low power and sleep guard
  // Suspend stops the 48 MHz clock and parks the transceiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_clk_gate_en <= 1'b0;
      xcvr_low_power <= 1'b1;
      usb_pins_owned <= 1'b0;
      analog_en <= 1'b0;
      sleep_block <= 1'b0;
    end else if (clk_en) begin
      usb_clk_gate_en <= powered && !pwr_reg[`UOSP_PW_SUSPEND];
      xcvr_low_power <= !powered || pwr_reg[`UOSP_PW_SUSPEND];
      usb_pins_owned <= powered;
      analog_en <= powered;
      sleep_block <= pwr_reg[`UOSP_PW_SLPGRD] &&
                     (sync2_reg[6] ||
                      evt_flag_reg[`UOSP_EV_ACTIVITY]);
    end
  end

endmodule

// ===== rtl/uosp_consts.svh
// Offsets, field positions, reset values and timing counts for uosp.
// Included by the package and the design; definitions only.
`ifndef UOSP_CONSTS_SVH
`define UOSP_CONSTS_SVH

`define UOSP_OFF_STATUS 12'h000
`define UOSP_OFF_CONTROL 12'h004
`define UOSP_OFF_POWER 12'h008
`define UOSP_OFF_EVT_FLAG 12'h00C
`define UOSP_OFF_EVT_MASK 12'h010

`define UOSP_ST_ID 7
`define UOSP_ST_LSTABLE 5
`define UOSP_ST_SESSVALID 3
`define UOSP_ST_SESSEND 2
`define UOSP_ST_VBUSVALID 0

`define UOSP_CT_DP_PU 7
`define UOSP_CT_DM_PU 6
`define UOSP_CT_DP_PD 5
`define UOSP_CT_DM_PD 4
`define UOSP_CT_VBUS_ON 3
`define UOSP_CT_SW_LINE 2
`define UOSP_CT_VBUS_CHG 1
`define UOSP_CT_VBUS_DIS 0
`define UOSP_CT_MASK 8'hFF

`define UOSP_PW_ACTPND 7
`define UOSP_PW_SLPGRD 4
`define UOSP_PW_BUSY 3
`define UOSP_PW_SUSPEND 1
`define UOSP_PW_ENABLE 0
`define UOSP_PW_WMASK 8'h13

`define UOSP_EV_ID 0
`define UOSP_EV_LSTABLE 1
`define UOSP_EV_SESSVALID 2
`define UOSP_EV_SESSEND 3
`define UOSP_EV_VBUSVALID 4
`define UOSP_EV_ACTIVITY 5
`define UOSP_EV_WIDTH 6

`define UOSP_CTRL_RESET 8'h00
`define UOSP_PWR_RESET 8'h00

`define UOSP_CLK_HZ 40000000
`define UOSP_STABLE_US 1000
`define UOSP_STABLE_CYC ((`UOSP_CLK_HZ / 1000000) * `UOSP_STABLE_US)
`define UOSP_SETTLE_CYC 16

`endif

// ===== rtl/uosp_pkg.sv
// Types for the uosp OTG status and power control block.
// Constants live in uosp_consts.svh.
package uosp_pkg;
  `include "uosp_consts.svh"
  typedef logic [31:0] uosp_word_t;
  typedef logic [11:0] uosp_addr_t;
  typedef enum logic [2:0] {
    UOSP_OFF = 3'b001,
    UOSP_ON = 3'b010,
    UOSP_SETTLE = 3'b100
  } uosp_pstate_t;
endpackage

// ===== verif/uosp_partner.sv
// Cable, line and VBUS model at the far side of the uosp block.
// Assumes the bench sets cable type, host supply, line and activity.
`timescale 1ns/1ps
module uosp_partner (
  // From bench
  input wire logic a_cable,
  input wire logic ext_vbus,
  input wire logic [1:0] line,
  input wire logic act,
  // From block
  input wire logic vbus_power_on,
  // To block
  output logic cable_identity,
  output logic single_ended_zero,
  output logic j_line_state,
  output logic sess_valid_cmp,
  output logic sess_end_cmp,
  output logic vbus_valid_cmp,
  output logic bus_activity
);
  logic vb;
  // Own supply or far host powers VBUS
  assign vb = ext_vbus | vbus_power_on;
  assign cable_identity = !a_cable;
  assign {single_ended_zero, j_line_state} = line;
  assign sess_valid_cmp = vb;
  assign sess_end_cmp = !vb;
  assign vbus_valid_cmp = vb & a_cable;
  assign bus_activity = act;
endmodule

// ===== verif/uosp_otg_ctrl_checker.sv
// Port-level assertions for uosp_otg_ctrl.
// Assumes the bind at the foot of this file.
`timescale 1ns/1ps
module uosp_checker
  import uosp_pkg::*;
#(
  parameter int unsigned STABLE_CYC = 20
) (
  // System and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire uosp_pkg::uosp_addr_t paddr,
  input wire uosp_pkg::uosp_word_t pwdata,
  input wire logic [3:0] pstrb,
  input wire uosp_pkg::uosp_word_t prdata,
  input wire logic pslverr,
  // Outputs watched
  input wire logic vbus_charge_en,
  input wire logic usb_clk_gate_en,
  input wire logic xcvr_low_power,
  input wire logic usb_pins_owned,
  input wire logic analog_en,
  input wire logic irq
);
  logic wacc;
  logic unm;
  assign wacc = psel && penable && pwrite && clk_en && pstrb[0];
  assign unm = paddr > 12'h010 || paddr[1:0] != 2'h0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_slverr_map: assert property (psel && penable |-> pslverr == unm)
    else $error("slave error wrong");
  a_chg_write: assert property (wacc && paddr == 12'h004 &&
    usb_pins_owned |-> ##2 vbus_charge_en == $past(pwdata[1], 2))
    else $error("charge enable wrong");
  a_pwr_write: assert property (wacc && paddr == 12'h008 |->
    ##2 usb_pins_owned == $past(pwdata[0], 2))
    else $error("pin ownership wrong");
  a_pwr_susp: assert property (wacc && paddr == 12'h008 &&
    pwdata[1:0] == 2'h3 |-> ##2 !usb_clk_gate_en && xcvr_low_power)
    else $error("suspend not taken");
  a_resume_run: assert property (wacc && paddr == 12'h008 &&
    pwdata[1:0] == 2'h1 |-> ##2 usb_clk_gate_en && !xcvr_low_power)
    else $error("clock not resumed");
  a_gate_lowp: assert property (usb_clk_gate_en |-> !xcvr_low_power)
    else $error("clock on in low power");
  a_off_quiet: assert property (!usb_pins_owned |->
    !analog_en && !usb_clk_gate_en)
    else $error("active while off");
  a_mask_clr: assert property (wacc && paddr == 12'h010 &&
    pwdata[5:0] == 6'h0 |=> !irq)
    else $error("irq while masked");
  c_ctrl: cover property (wacc && paddr == 12'h004);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule

bind uosp_otg_ctrl uosp_checker #(.STABLE_CYC(STABLE_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .vbus_charge_en(vbus_charge_en), .usb_clk_gate_en(usb_clk_gate_en),
  .xcvr_low_power(xcvr_low_power), .usb_pins_owned(usb_pins_owned),
  .analog_en(analog_en), .irq(irq));

// ===== verif/tb.sv
// Self-checking bench for uosp_otg_ctrl over APB.
// Assumes uosp_partner as far side; 1 ms shortened to 20 cycles.
`timescale 1ns/1ps
module tb;
  import uosp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  uosp_addr_t paddr = '0;
  uosp_word_t pwdata = '0, prdata, d;
  logic pready, pslverr, err, a_cable = 0, ext_vbus = 0, act = 0;
  logic [1:0] line = 2'h2;
  logic [3:0] hw_line_res = 4'hA, pstrb = 4'hF;
  logic clk_en = 1'b1;
  logic cable_identity, single_ended_zero, j_line_state, sess_valid_cmp;
  logic sess_end_cmp, vbus_valid_cmp, bus_activity, irq, sleep_block;
  logic dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en;
  logic dminus_pulldown_en, vbus_power_on, vbus_charge_en;
  logic vbus_discharge_en, usb_clk_gate_en, xcvr_low_power;
  logic usb_pins_owned, analog_en;
  int failures = 0, n_checks = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  uosp_otg_ctrl #(.STABLE_CYC(20)) DUT (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .cable_identity, .single_ended_zero,
    .j_line_state, .sess_valid_cmp, .sess_end_cmp, .vbus_valid_cmp,
    .bus_activity, .hw_line_res, .dplus_pullup_en, .dminus_pullup_en,
    .dplus_pulldown_en, .dminus_pulldown_en, .vbus_power_on,
    .vbus_charge_en, .vbus_discharge_en, .usb_clk_gate_en,
    .xcvr_low_power, .usb_pins_owned, .analog_en, .sleep_block, .irq);
  uosp_partner u_far (.a_cable, .ext_vbus, .line, .act, .vbus_power_on,
    .cable_identity, .single_ended_zero, .j_line_state, .sess_valid_cmp,
    .sess_end_cmp, .vbus_valid_cmp, .bus_activity);
  task finish_test;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input uosp_word_t g, input uosp_word_t e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task bus(input logic we, input uosp_addr_t a, input uosp_word_t v);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task t_reset;
    bus(0, 12'h004, 0);
    chk(d, 32'h0);
    bus(0, 12'h008, 0);
    chk(d, 32'h0);
    bus(1, 12'h014, 32'hFFFFFFFF);
    bus(0, 12'h014, 0);
    chk({d[31:1], err}, 32'h1);
  endtask
  task t_status;
    for (int k = 0; k < 4; k++) begin
      a_cable <= k[0];
      ext_vbus <= k[1];
      w(30);
      bus(0, 12'h000, 0);
      chk(d, {24'h0, !k[0], 3'h2, k[1], !k[1], 1'b0,
        k[1] & k[0]});
    end
    ext_vbus <= 1'b0;
  endtask
  task t_line;
    repeat (5) begin
      line <= ~line;
      w(1);
    end
    w(6);
    bus(0, 12'h000, 0);
    chk(32'(d[5]), 32'h0);
    w(25);
    bus(0, 12'h000, 0);
    chk(32'(d[5]), 32'h1);
  endtask
  task t_ctrl;
    logic [7:0] v;
    bus(1, 12'h008, 1);
    for (int k = 0; k < 4; k++) begin
      v = 8'h80 >> k;
      bus(1, 12'h004, {24'h0, v | 8'h04});
      w(2);
      chk(32'({dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
        dminus_pulldown_en}), 32'(v[7:4]));
    end
    bus(1, 12'h004, 32'h0B);
    w(2);
    chk(32'({dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
      dminus_pulldown_en, vbus_power_on, vbus_charge_en,
      vbus_discharge_en}), 32'({hw_line_res, 3'h7}));
    bus(1, 12'h004, 32'hFFFFFFFF);
    bus(0, 12'h004, 0);
    chk(d, 32'hFF);
    bus(1, 12'h004, 0);
    w(2);
    chk(32'({vbus_power_on, vbus_charge_en, vbus_discharge_en}), 0);
    pstrb <= 4'h0;
    bus(1, 12'h004, 32'hFF);
    pstrb <= 4'hF;
    bus(0, 12'h004, 0);
    chk(d, 32'h0);
  endtask
  task t_power;
    bus(1, 12'h008, 32'h3);
    w(2);
    chk(32'({usb_clk_gate_en, xcvr_low_power}), 32'h1);
    chk(32'({usb_pins_owned, analog_en}), 32'h3);
    bus(1, 12'h008, 32'hFFFFFFFF);
    bus(0, 12'h008, 0);
    chk(d, 32'h1B);
    bus(1, 12'h008, 32'h1);
    w(2);
    chk(32'({usb_clk_gate_en, xcvr_low_power}), 32'h2);
    bus(1, 12'h008, 0);
    bus(0, 12'h008, 0);
    chk(d, 32'h08);
    w(20);
    bus(0, 12'h008, 0);
    chk(d, 32'h0);
    chk(32'({usb_pins_owned, analog_en}), 32'h0);
  endtask
  task t_irq;
    bus(1, 12'h008, 1);
    bus(1, 12'h00C, 32'h3F);
    act <= 1'b1;
    w(4);
    act <= 1'b0;
    w(4);
    bus(0, 12'h008, 0);
    chk({d[31:1], irq}, 32'h88);
    bus(1, 12'h008, 32'h11);
    w(2);
    chk(32'(sleep_block), 32'h1);
    bus(1, 12'h008, 1);
    w(2);
    chk(32'(sleep_block), 32'h0);
    bus(1, 12'h010, 32'h20);
    bus(0, 12'h008, 0);
    chk({d[31:1], irq}, 32'h9);
    bus(1, 12'h010, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1, 12'h010, 32'h20);
    bus(1, 12'h00C, 32'h20);
    chk(32'(irq), 32'h0);
    clk_en <= 1'b0;
    act <= 1'b1;
    w(4);
    act <= 1'b0;
    clk_en <= 1'b1;
    w(4);
    bus(0, 12'h00C, 0);
    chk(d, 32'h0);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      finish_test;
    end
  end
  initial begin
    w(2);
    presetn <= 1'b1;
    w(1);
    t_reset;
    t_status;
    t_line;
    t_ctrl;
    t_power;
    t_irq;
    finish_test;
  end
endmodule
